// File: core/ceclf_regs.svh
/*
 Bit positions, reset value, write mask and decode constants for the lower
 35 bits of the core extended control register. Assumes it is included once
 by the package and by the control block.
*/
`ifndef CECLF_REGS_SVH
`define CECLF_REGS_SVH

`define CECLF_W 35
`define CECLF_RESET 35'h3_4054_3000
`define CECLF_WR_MASK 35'h7_fffc_b3fb

`define CECLF_CLEAN_EVICT_SUPPRESS 34
`define CECLF_LOAD_ATOMIC_FORCE_LOCAL 33
`define CECLF_ACQUIRE_ATOMIC_LOCAL_FILL 32
`define CECLF_STORE_ATOMIC_LOCAL_FILL 31
`define CECLF_RELEASE_ATOMIC_LOCAL_FILL 30
`define CECLF_LOAD_ATOMIC_LOCAL_FILL 29
`define CECLF_TLP_OFF 28
`define CECLF_TLP_AGGR 27
`define CECLF_TLB_ABORT_EN 26
`define CECLF_THR_L2_LSB 24
`define CECLF_THR_L3_LSB 22
`define CECLF_THR_L4_LSB 20
`define CECLF_THR_DRAM_LSB 18
`define CECLF_PF_OFF 15
`define CECLF_L2_DIST_LSB 12
`define CECLF_STS_PF_OFF 9
`define CECLF_STI_PF_OFF 8
`define CECLF_PF_AGGR_LSB 6
`define CECLF_RPF_AGGR_LSB 4
`define CECLF_RPF_SINGLE_TRAIN 3
`define CECLF_ERR_READ_ZERO 1
`define CECLF_LLC_EXTERNAL 0

// Stream thresholds in bytes, zero means direct streaming is off
`define CECLF_THR_W 24
`define CECLF_B_256 24'h00_0100
`define CECLF_B_4K 24'h00_1000
`define CECLF_B_8K 24'h00_2000
`define CECLF_B_128K 24'h02_0000
`define CECLF_B_256K 24'h04_0000
`define CECLF_B_512K 24'h08_0000
`define CECLF_B_1M 24'h10_0000
`define CECLF_B_2M 24'h20_0000
`define CECLF_SOLE_SHIFT 1

// L2 stride prefetch distances in lines, zero means hardware managed
`define CECLF_DIST_0 8'h16
`define CECLF_DIST_1 8'h28
`define CECLF_DIST_2 8'h3c

`endif

// File: core/ceclf_pkg.sv
/*
 Types shared by the extended control block. Assumes ceclf_regs.svh is on
 the include path.
*/
`default_nettype none
`include "ceclf_regs.svh"

package ceclf_pkg;
    typedef logic [`CECLF_W-1:0] ceclf_word_t;
    typedef enum logic [1:0] {
        CECLF_AT_LOAD = 2'h0,
        CECLF_AT_STORE = 2'h1,
        CECLF_AT_ACQUIRE = 2'h2,
        CECLF_AT_RELEASE = 2'h3
    } ceclf_atomic_e;
    typedef enum logic [1:0] {
        CECLF_PF_DYNAMIC = 2'h0,
        CECLF_PF_CONS = 2'h1,
        CECLF_PF_VERY_CONS = 2'h2,
        CECLF_PF_MOST_CONS = 2'h3
    } ceclf_pf_e;
endpackage

`default_nettype wire

// File: core/ceclf_ctrl.sv
/*
 Lower 35 bits of the core extended control register with the decode that
 steers evictions, atomics, streaming stores, prefetchers, TLB conflict
 aborts and error record reads. Assumes a system register port on the core
 clock: one-cycle read and write strobes, and event inputs from core logic
 on the same clock.
*/
// Function
// - Bit 34 set suppresses messages for clean line evictions.
// - Bit 33 set forces load atomics local by filling the line.
// - Bit 32 set lets acquire atomics make one fill, else far.
// - Bit 31 set lets store atomics make one fill, else far.
// - Bit 30 set lets release atomics make one fill, else far.
// - Bit 29 set lets load atomics make one fill, else far unless bit 33 is set.
// - Bit 28 disables transient load prediction; bit 27 picks aggressive threshold.
// - TLB conflict abort raised only while bit 26 is set.
// - Bits 25:24 pick L2 stream threshold 256B/4KB/8KB/off.
// - Bits 23:22 pick L3 stream threshold 128KB/256KB/512KB/off.
// - Bits 21:20 pick L4 stream threshold 256KB/512KB/1MB/off.
// - Bits 19:18 pick DRAM stream threshold 512KB/1MB/2MB/off.
// - Sole active requestor may scale L4 and DRAM thresholds up.
// - Bit 15 set disables data-side hardware prefetching.
// - Bits 13:12 pick L2 stride distance 22/40/60/dynamic.
// - Bit 9 disables store-stride prefetch; bit 8 disables issue prefetch.
// - Bits 7:6 pick general prefetcher aggressiveness.
// - Bits 5:4 pick region aggressiveness; 11 turns region prefetcher off.
// - Bit 3 set always trains history table on single accesses.
// - Bit 1 set makes error record reads return zero.
// - Bit 0 marks last-level cache external, enabling data-source optimizations.
`timescale 1ns/100ps
`default_nettype none
`include "ceclf_regs.svh"

module ceclf_ctrl
    import ceclf_pkg::*;
#(
    parameter int ERR_W = 64
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // System register port
    input wire logic wr_en,
    input wire logic [`CECLF_W-1:0] wr_data,
    input wire logic rd_en,
    output logic [`CECLF_W-1:0] rd_data,
    output logic rd_valid,
    // Core events
    input wire logic clean_evict_in,
    input wire logic tlb_conflict_in,
    input wire logic sole_requestor,
    input wire logic atomic_valid,
    input wire ceclf_atomic_e atomic_kind,
    input wire logic line_exclusive,
    input wire logic err_rd_en,
    input wire logic [ERR_W-1:0] err_rd_raw,
    // Event results
    output logic evict_msg_send,
    output logic tlb_abort,
    output logic atomic_done,
    output logic atomic_local,
    output logic atomic_fill,
    output logic err_rd_valid,
    output logic [ERR_W-1:0] err_rd_data,
    // Decoded controls
    output logic tlp_enable,
    output logic tlp_aggressive,
    output logic [`CECLF_THR_W-1:0] thr_l2,
    output logic [`CECLF_THR_W-1:0] thr_l3,
    output logic [`CECLF_THR_W-1:0] thr_l4,
    output logic [`CECLF_THR_W-1:0] thr_dram,
    output logic data_pf_enable,
    output logic [7:0] l2_stride_dist,
    output logic store_stride_pf_enable,
    output logic store_issue_pf_enable,
    output ceclf_pf_e pf_aggr,
    output logic region_pf_enable,
    output logic region_single_train,
    output logic llc_external
);

    ceclf_word_t ctrl_ff;
    ceclf_word_t nxt_ctrl;
    logic [`CECLF_W-1:0] rd_data_ff;
    logic rd_valid_ff;
    logic evict_ff, abort_ff, at_done_ff, at_local_ff, at_fill_ff;
    logic err_valid_ff;
    logic [ERR_W-1:0] err_data_ff;
    logic [`CECLF_THR_W-1:0] l2_ff, l3_ff, l4_ff, dram_ff;
    logic [7:0] dist_ff;
    logic nxt_local, nxt_fill, fill_bit;
    localparam ceclf_word_t RST_WORD = `CECLF_RESET;
    logic tlp_en_ff, tlp_aggr_ff, pf_en_ff, sts_en_ff, sti_en_ff;
    logic rpf_en_ff, single_train_ff, llc_ext_ff;
    ceclf_pf_e pf_aggr_ff;

    // Threshold lookup, zero for the off code
    function automatic logic [`CECLF_THR_W-1:0] thr_pick(
        input logic [1:0] code,
        input logic [`CECLF_THR_W-1:0] t0,
        input logic [`CECLF_THR_W-1:0] t1,
        input logic [`CECLF_THR_W-1:0] t2
    );
        case (code)
            2'h0: thr_pick = t0;
            2'h1: thr_pick = t1;
            2'h2: thr_pick = t2;
            default: thr_pick = '0;
        endcase
    endfunction

    // Reserved positions never take a write
    assign nxt_ctrl = wr_data & `CECLF_WR_MASK;

    // Control word, held until the next write or reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_ff <= `CECLF_RESET;
        end else if (wr_en) begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    // Level controls load with the control word, so they never lag it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tlp_en_ff <= !RST_WORD[`CECLF_TLP_OFF];
            tlp_aggr_ff <= RST_WORD[`CECLF_TLP_AGGR];
            pf_en_ff <= !RST_WORD[`CECLF_PF_OFF];
            sts_en_ff <= !RST_WORD[`CECLF_STS_PF_OFF];
            sti_en_ff <= !RST_WORD[`CECLF_STI_PF_OFF];
            pf_aggr_ff <= ceclf_pf_e'(RST_WORD[`CECLF_PF_AGGR_LSB+:2]);
            rpf_en_ff <= RST_WORD[`CECLF_RPF_AGGR_LSB+:2] != 2'h3;
            single_train_ff <= RST_WORD[`CECLF_RPF_SINGLE_TRAIN];
            llc_ext_ff <= RST_WORD[`CECLF_LLC_EXTERNAL];
        end else if (wr_en) begin
            tlp_en_ff <= !nxt_ctrl[`CECLF_TLP_OFF];
            tlp_aggr_ff <= nxt_ctrl[`CECLF_TLP_AGGR];
            pf_en_ff <= !nxt_ctrl[`CECLF_PF_OFF];
            sts_en_ff <= !nxt_ctrl[`CECLF_STS_PF_OFF];
            sti_en_ff <= !nxt_ctrl[`CECLF_STI_PF_OFF];
            pf_aggr_ff <= ceclf_pf_e'(nxt_ctrl[`CECLF_PF_AGGR_LSB+:2]);
            rpf_en_ff <= nxt_ctrl[`CECLF_RPF_AGGR_LSB+:2] != 2'h3;
            single_train_ff <= nxt_ctrl[`CECLF_RPF_SINGLE_TRAIN];
            llc_ext_ff <= nxt_ctrl[`CECLF_LLC_EXTERNAL];
        end
    end

    // Read answer one cycle after the strobe, old value if written together
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data_ff <= '0;
            rd_valid_ff <= 1'b0;
        end else begin
            rd_valid_ff <= rd_en;
            if (rd_en) begin
                rd_data_ff <= ctrl_ff;
            end
        end
    end

    // Clean eviction messages and TLB conflict aborts
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            evict_ff <= 1'b0;
            abort_ff <= 1'b0;
        end else begin
            evict_ff <= clean_evict_in && !ctrl_ff[`CECLF_CLEAN_EVICT_SUPPRESS];
            abort_ff <= tlb_conflict_in && ctrl_ff[`CECLF_TLB_ABORT_EN];
        end
    end

    // Fill permission for the atomic class at hand
    always_comb begin
        case (atomic_kind)
            CECLF_AT_LOAD: fill_bit = ctrl_ff[`CECLF_LOAD_ATOMIC_LOCAL_FILL];
            CECLF_AT_STORE: fill_bit = ctrl_ff[`CECLF_STORE_ATOMIC_LOCAL_FILL];
            CECLF_AT_ACQUIRE: fill_bit = ctrl_ff[`CECLF_ACQUIRE_ATOMIC_LOCAL_FILL];
            CECLF_AT_RELEASE: fill_bit = ctrl_ff[`CECLF_RELEASE_ATOMIC_LOCAL_FILL];
            default: fill_bit = 1'b0;
        endcase
    end

    // Local or far choice; a miss is local only with one fill
    always_comb begin
        nxt_local = line_exclusive || fill_bit;
        nxt_fill = !line_exclusive && fill_bit;
        if (atomic_kind == CECLF_AT_LOAD && ctrl_ff[`CECLF_LOAD_ATOMIC_FORCE_LOCAL]) begin
            nxt_local = 1'b1;
            nxt_fill = !line_exclusive;
        end
    end

    // Atomic decision register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            at_done_ff <= 1'b0;
            at_local_ff <= 1'b0;
            at_fill_ff <= 1'b0;
        end else begin
            at_done_ff <= atomic_valid;
            at_local_ff <= atomic_valid && nxt_local;
            at_fill_ff <= atomic_valid && nxt_fill;
        end
    end

    // Error record reads, forced to zero when selected
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            err_valid_ff <= 1'b0;
            err_data_ff <= '0;
        end else begin
            err_valid_ff <= err_rd_en;
            if (err_rd_en) begin
                err_data_ff <= ctrl_ff[`CECLF_ERR_READ_ZERO] ? '0 : err_rd_raw;
            end
        end
    end

    // Streaming store thresholds and stride distance
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            l2_ff <= '0;
            l3_ff <= '0;
            l4_ff <= '0;
            dram_ff <= '0;
            dist_ff <= '0;
        end else begin
            l2_ff <= thr_pick(ctrl_ff[`CECLF_THR_L2_LSB+:2],
                `CECLF_B_256, `CECLF_B_4K, `CECLF_B_8K);
            l3_ff <= thr_pick(ctrl_ff[`CECLF_THR_L3_LSB+:2],
                `CECLF_B_128K, `CECLF_B_256K, `CECLF_B_512K);
            l4_ff <= thr_pick(ctrl_ff[`CECLF_THR_L4_LSB+:2],
                `CECLF_B_256K, `CECLF_B_512K, `CECLF_B_1M)
                << (sole_requestor ? `CECLF_SOLE_SHIFT : 0);
            dram_ff <= thr_pick(ctrl_ff[`CECLF_THR_DRAM_LSB+:2],
                `CECLF_B_512K, `CECLF_B_1M, `CECLF_B_2M)
                << (sole_requestor ? `CECLF_SOLE_SHIFT : 0);
            case (ctrl_ff[`CECLF_L2_DIST_LSB+:2])
                2'h0: dist_ff <= `CECLF_DIST_0;
                2'h1: dist_ff <= `CECLF_DIST_1;
                2'h2: dist_ff <= `CECLF_DIST_2;
                default: dist_ff <= 8'h00;
            endcase
        end
    end

    // Outputs straight from the registers
    assign rd_data = rd_data_ff;
    assign rd_valid = rd_valid_ff;
    assign evict_msg_send = evict_ff;
    assign tlb_abort = abort_ff;
    assign atomic_done = at_done_ff;
    assign atomic_local = at_local_ff;
    assign atomic_fill = at_fill_ff;
    assign err_rd_valid = err_valid_ff;
    assign err_rd_data = err_data_ff;
    assign thr_l2 = l2_ff;
    assign thr_l3 = l3_ff;
    assign thr_l4 = l4_ff;
    assign thr_dram = dram_ff;
    assign l2_stride_dist = dist_ff;

    // Direct field controls, each from its own flop
    assign tlp_enable = tlp_en_ff;
    assign tlp_aggressive = tlp_aggr_ff;
    assign data_pf_enable = pf_en_ff;
    assign store_stride_pf_enable = sts_en_ff;
    assign store_issue_pf_enable = sti_en_ff;
    assign pf_aggr = pf_aggr_ff;
    assign region_pf_enable = rpf_en_ff;
    assign region_single_train = single_train_ff;
    assign llc_external = llc_ext_ff;

    // Checks
    sequence rd_req_s;
        rd_en;
    endsequence
    sequence rd_ans_s;
        rd_valid && rd_data == $past(ctrl_ff);
    endsequence
    sequence miss_store_s;
        atomic_valid && atomic_kind == CECLF_AT_STORE && !line_exclusive
            && !ctrl_ff[`CECLF_STORE_ATOMIC_LOCAL_FILL];
    endsequence

    write_store_a: assert property (@(posedge clk) disable iff (rst)
        wr_en |=> ctrl_ff == $past(nxt_ctrl))
        else $error("written value not held");
    resv_zero_a: assert property (@(posedge clk) disable iff (rst)
        (ctrl_ff & ~`CECLF_WR_MASK) == '0)
        else $error("reserved bit set");
    read_answer_a: assert property (@(posedge clk) disable iff (rst)
        rd_req_s |=> rd_ans_s)
        else $error("read answer wrong");
    evict_gate_a: assert property (@(posedge clk) disable iff (rst)
        clean_evict_in |=> evict_msg_send == !$past(ctrl_ff[34]))
        else $error("evict message gating wrong");
    tlb_abort_a: assert property (@(posedge clk) disable iff (rst)
        tlb_abort |-> $past(ctrl_ff[26] && tlb_conflict_in))
        else $error("abort without enable");
    err_zero_a: assert property (@(posedge clk) disable iff (rst)
        err_rd_en && ctrl_ff[1] |=> err_rd_valid && err_rd_data == '0)
        else $error("error record not zero");
    store_far_a: assert property (@(posedge clk) disable iff (rst)
        miss_store_s |=> atomic_done && !atomic_local && !atomic_fill)
        else $error("store atomic not far");
    force_local_a: assert property (@(posedge clk) disable iff (rst)
        atomic_valid && atomic_kind == CECLF_AT_LOAD && ctrl_ff[33] && !line_exclusive
            |=> atomic_local && atomic_fill)
        else $error("load atomic not forced local");
    l2_off_a: assert property (@(posedge clk) disable iff (rst)
        ctrl_ff[25:24] == 2'h3 && !wr_en |=> ##1 thr_l2 == '0)
        else $error("l2 stream not off");
    region_off_a: assert property (@(posedge clk) disable iff (rst)
        region_pf_enable |-> ctrl_ff[5:4] != 2'h3)
        else $error("region prefetcher on at most conservative");

endmodule

`default_nettype wire

// File: dv/tb_top.sv
/*
 Self-checking bench for the extended control block: register port,
 decoded controls and event paths. Assumes the design package and
 header are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top import ceclf_pkg::*;;
    localparam logic [34:0] RSV = 35'h0_0003_4c04;
    localparam logic [34:0] RST_VAL = 35'h3_4054_3000;
    logic clk, rst, wr_en, rd_en, rd_valid, clean_evict_in, tlb_conflict_in;
    logic sole_requestor, atomic_valid, line_exclusive, err_rd_en;
    logic evict_msg_send, tlb_abort, atomic_done, atomic_local, atomic_fill;
    logic err_rd_valid, tlp_enable, tlp_aggressive, data_pf_enable, llc_external;
    logic store_stride_pf_enable, store_issue_pf_enable, region_pf_enable;
    logic region_single_train;
    logic [34:0] wr_data, rd_data, cur;
    logic [63:0] err_rd_raw, err_rd_data;
    logic [23:0] thr_l2, thr_l3, thr_l4, thr_dram;
    logic [7:0] l2_stride_dist;
    logic [31:0] rng;
    ceclf_atomic_e atomic_kind;
    ceclf_pf_e pf_aggr;
    int err_total, checks_done;
    logic [34:0] rd_q[$];
    logic [69:0] ev_q[$];

    ceclf_ctrl #(.ERR_W(64)) DUT (.clk(clk), .rst(rst), .wr_en(wr_en), .wr_data(wr_data),
        .rd_en(rd_en), .rd_data(rd_data), .rd_valid(rd_valid),
        .clean_evict_in(clean_evict_in), .tlb_conflict_in(tlb_conflict_in),
        .sole_requestor(sole_requestor), .atomic_valid(atomic_valid),
        .atomic_kind(atomic_kind), .line_exclusive(line_exclusive),
        .err_rd_en(err_rd_en), .err_rd_raw(err_rd_raw), .evict_msg_send(evict_msg_send),
        .tlb_abort(tlb_abort), .atomic_done(atomic_done), .atomic_local(atomic_local),
        .atomic_fill(atomic_fill), .err_rd_valid(err_rd_valid), .err_rd_data(err_rd_data),
        .tlp_enable(tlp_enable), .tlp_aggressive(tlp_aggressive), .thr_l2(thr_l2),
        .thr_l3(thr_l3), .thr_l4(thr_l4), .thr_dram(thr_dram),
        .data_pf_enable(data_pf_enable), .l2_stride_dist(l2_stride_dist),
        .store_stride_pf_enable(store_stride_pf_enable),
        .store_issue_pf_enable(store_issue_pf_enable), .pf_aggr(pf_aggr),
        .region_pf_enable(region_pf_enable), .region_single_train(region_single_train),
        .llc_external(llc_external));

    // 10 MHz core clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input logic [69:0] seen, input logic [69:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction

    // Threshold in bytes for a two-bit code, top code means off
    function automatic logic [23:0] thr(input logic [1:0] c, input logic [23:0] a, b, d);
        case (c)
            2'h0: return a;
            2'h1: return b;
            2'h2: return d;
            default: return 24'h0;
        endcase
    endfunction

    // One register port cycle; a same-cycle read sees the old word
    task automatic access(input logic w, input logic r, input logic [34:0] v);
        @(negedge clk);
        wr_en = w;
        rd_en = r;
        wr_data = v;
        if (r) rd_q.push_back(cur);
        if (w) cur = v & ~RSV;
        @(negedge clk);
        wr_en = 1'b0;
        rd_en = 1'b0;
    endtask

    // Decoded controls two edges after the write
    task automatic check_decode;
        logic [1:0] k;
        logic [23:0] l4, dr;
        @(negedge clk);
        k = cur[13:12];
        l4 = thr(cur[21:20], 24'h04_0000, 24'h08_0000, 24'h10_0000) << sole_requestor;
        dr = thr(cur[19:18], 24'h08_0000, 24'h10_0000, 24'h20_0000) << sole_requestor;
        chk(70'({tlp_enable, tlp_aggressive, data_pf_enable, store_stride_pf_enable,
            store_issue_pf_enable, region_single_train, llc_external, region_pf_enable}),
            70'({~cur[28], cur[27], ~cur[15], ~cur[9], ~cur[8], cur[3], cur[0],
            cur[5:4] != 2'h3}), "levels");
        chk(70'(pf_aggr), 70'(cur[7:6]), "aggr");
        chk(70'(l2_stride_dist), 70'(k == 2'h0 ? 8'h16 : k == 2'h1 ? 8'h28 :
            k == 2'h2 ? 8'h3c : 8'h00), "dist");
        chk(70'({thr_l2, thr_l3}), 70'({thr(cur[25:24], 24'h100, 24'h1000, 24'h2000),
            thr(cur[23:22], 24'h02_0000, 24'h04_0000, 24'h08_0000)}), "thr");
        chk(70'({thr_l4, thr_dram}), 70'({l4, dr}), "thr far");
    endtask

    // Random event strobes, each noting the pulses it should cause
    task automatic events(input int n);
        logic [69:0] e;
        logic kb;
        repeat (n) begin
            @(negedge clk);
            rng = xs(rng);
            clean_evict_in = rng[0];
            tlb_conflict_in = rng[1];
            atomic_valid = rng[2];
            atomic_kind = ceclf_atomic_e'(rng[4:3]);
            line_exclusive = rng[5];
            err_rd_en = rng[6];
            err_rd_raw = {rng, ~rng};
            case (rng[4:3])
                2'h0: kb = cur[33] | cur[29];
                2'h1: kb = cur[31];
                2'h2: kb = cur[32];
                default: kb = cur[30];
            endcase
            e = {rng[0] & ~cur[34], rng[1] & cur[26], rng[2], rng[2] & (rng[5] | kb),
                rng[2] & ~rng[5] & kb, rng[6], cur[1] ? 64'h0 : {rng, ~rng}};
            if (|e[69:64]) ev_q.push_back(e);
        end
        @(negedge clk);
        {clean_evict_in, tlb_conflict_in, atomic_valid, err_rd_en} = 4'h0;
    endtask

    // Result watcher: takes the oldest note whenever a result shows
    initial begin
        logic [69:0] e;
        forever begin
            @(negedge clk);
            if (rd_valid === 1'b1) begin
                e = rd_q.size() ? 70'(rd_q.pop_front()) : '1;
                chk(70'(rd_data), e, "read");
            end
            if ((evict_msg_send | tlb_abort | atomic_done | err_rd_valid) === 1'b1) begin
                e = ev_q.size() ? ev_q.pop_front() : '1;
                chk(70'({evict_msg_send, tlb_abort, atomic_done, atomic_local, atomic_fill,
                    err_rd_valid}), 70'(e[69:64]), "event");
                if (e[64]) chk(70'(err_rd_data), 70'(e[63:0]), "record");
            end
        end
    end

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        wrap_up;
    end

    // Main sequence
    initial begin
        {rst, wr_en, rd_en, clean_evict_in, tlb_conflict_in} = 5'h10;
        {sole_requestor, atomic_valid, line_exclusive, err_rd_en} = 4'h0;
        wr_data = '0;
        err_rd_raw = '0;
        atomic_kind = CECLF_AT_LOAD;
        rng = 32'ha25e;
        cur = RST_VAL;
        err_total = 0;
        checks_done = 0;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        access(1'b0, 1'b1, '0);
        check_decode;
        for (int i = 0; i < 4; i++) begin
            sole_requestor = i[0];
            access(1'b1, 1'b0, 35'({18{i[1:0]}}));
            check_decode;
            access(1'b0, 1'b1, '0);
            events(10);
        end
        for (int i = 0; i < 12; i++) begin
            rng = xs(rng);
            sole_requestor = rng[9];
            access(1'b1, rng[8], {rng[2:0], rng});
            check_decode;
            access(1'b0, 1'b1, '0);
            events(16);
        end
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        cur = RST_VAL;
        access(1'b0, 1'b1, '0);
        check_decode;
        events(16);
        repeat (3) @(negedge clk);
        chk(70'(rd_q.size() + ev_q.size()), 70'h0, "pending");
        wrap_up;
    end
endmodule
`default_nettype wire
